/* hdl/smc_top.sv */
// Configuration registers of a humidity and temperature sensor with a framed serial link.
// Assumes the host owns link_clk_i, holds link_frame_i high over each 24-bit frame
// and leaves at least 8 core cycles between two writes.
// Function
// - Writing 1 to restart bit starts soft reset; bit clears itself afterwards.
// - Rate code 000 means one-shot; convert only when triggered.
// - Nonzero rate codes convert continuously at the listed periodic rates once the go bit is written.
// - Heater bit switches integrated heater off at 0, on at 1.
// - Pin enable 0 leaves alert pin undriven; 1 drives it.
// - Polarity bit 0 gives active low alert, 1 active high.
// - Mode bit 0 is clear-on-read alert, 1 comparator alert.
// - Temperature resolution field selects 14, 11 or 9 bit conversion.
// - Humidity resolution field selects 14, 11 or 9 bit conversion.
// - Channel field 00 measures both channels, 01 temperature only.
// - Writing 1 to go bit starts conversion; writing 0 does nothing.
// - Go bit clears itself as soon as the measurement begins.
// - Maker code bytes read at addresses fc and fd.
// - Part code bytes read at addresses fe and ff.
// - Device setup register sits at address 0e.
`timescale 1ns/1ps
module smc_top #(
  parameter int unsigned TICK_CYC = smc_pkg::TICK_CYC
) (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic link_clk_i,
  input wire logic link_frame_i,
  input wire logic link_sdi_i,
  output logic link_sdo_o,
  output logic link_sdo_oe_n_o,
  // Measurement engine
  input wire logic conv_done_i,
  input wire logic cmp_level_i,
  input wire logic flag_read_i,
  output logic conv_start_o,
  output logic [1:0] temp_res_o,
  output logic [1:0] humid_res_o,
  output logic [1:0] chan_sel_o,
  output logic heater_on_o,
  output logic restarting_o,
  // Alert pin
  input wire logic alert_i,
  output logic alert_o,
  output logic alert_oe_n_o
);

  localparam int SR_MAX = smc_pkg::SRST_CYC + 2;

  typedef struct packed {
    smc_pkg::smc_state_t st;
    smc_pkg::smc_dev_t dev;
    smc_pkg::smc_meas_t meas;
    logic [7:0] sr_cnt;
    logic [31:0] cyc;
    logic [10:0] ticks;
    logic start;
    logic flag;
    logic alert;
    logic alert_oe_n;
    logic [1:0] wr_sync;
    logic wr_seen;
    logic [1:0] ack_sync;
    logic pub_tgl;
    logic [15:0] pub;
  } smc_core_t;

  // Frame-scoped link state, cleared whenever the frame is idle
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] rx;
    logic rd;
    logic [7:0] tx;
    logic sdo;
    logic oe_n;
  } smc_frame_t;

  // Link state that must outlive a frame
  typedef struct packed {
    logic wr_tgl;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [1:0] pub_sync;
    logic ack_tgl;
    logic [15:0] snap;
  } smc_hold_t;

  smc_core_t c;
  smc_core_t next_c;
  smc_frame_t f;
  smc_frame_t next_f;
  smc_hold_t h;
  smc_hold_t next_h;
  logic frame_rst_n;

  function automatic logic [10:0] rate_ticks(input logic [2:0] code);
    case (code)
      3'h1: rate_ticks = smc_pkg::TICKS_R1;
      3'h2: rate_ticks = smc_pkg::TICKS_R2;
      3'h3: rate_ticks = smc_pkg::TICKS_R3;
      3'h4: rate_ticks = smc_pkg::TICKS_R4;
      3'h5: rate_ticks = smc_pkg::TICKS_R5;
      3'h6: rate_ticks = smc_pkg::TICKS_R6;
      3'h7: rate_ticks = smc_pkg::TICKS_R7;
      default: rate_ticks = 11'h000;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [15:0] snap);
    case (addr)
      smc_pkg::ADDR_DEV: read_byte = snap[15:8];
      smc_pkg::ADDR_MEAS: read_byte = snap[7:0];
      smc_pkg::ADDR_MAKER_LO: read_byte = smc_pkg::MAKER_CODE[7:0];
      smc_pkg::ADDR_MAKER_HI: read_byte = smc_pkg::MAKER_CODE[15:8];
      smc_pkg::ADDR_PART_LO: read_byte = smc_pkg::PART_CODE[7:0];
      smc_pkg::ADDR_PART_HI: read_byte = smc_pkg::PART_CODE[15:8];
      default: read_byte = 8'h00;
    endcase
  endfunction

  // Core domain
  always_comb begin
    logic alert_act;
    alert_act = 1'b0;
    next_c = c;
    next_c.start = 1'b0;
    next_c.wr_sync = {c.wr_sync[0], h.wr_tgl};
    next_c.wr_seen = c.wr_sync[1];
    next_c.ack_sync = {c.ack_sync[0], h.ack_tgl};
    case (c.st)
      smc_pkg::ST_SRST: begin
        if (c.sr_cnt == 8'h00) begin
          next_c.dev = smc_pkg::REG_RESET;
          next_c.meas = smc_pkg::REG_RESET;
          next_c.st = smc_pkg::ST_IDLE;
        end else begin
          next_c.sr_cnt = c.sr_cnt - 8'h01;
        end
      end
      smc_pkg::ST_IDLE, smc_pkg::ST_RUN: begin
        if (c.meas.conversion_go) begin
          next_c.start = 1'b1;
          next_c.meas.conversion_go = 1'b0;
          next_c.cyc = 32'h0;
          next_c.ticks = 11'h000;
          if (c.dev.conversion_rate_select == smc_pkg::RATE_ONE_SHOT) begin
            next_c.st = smc_pkg::ST_IDLE;
          end else begin
            next_c.st = smc_pkg::ST_RUN;
          end
        end else if (c.st == smc_pkg::ST_RUN) begin
          if (c.dev.conversion_rate_select == smc_pkg::RATE_ONE_SHOT) begin
            next_c.st = smc_pkg::ST_IDLE;
          end else if (c.cyc == 32'(TICK_CYC - 1)) begin
            next_c.cyc = 32'h0;
            next_c.ticks = c.ticks + 11'h001;
            if (c.ticks + 11'h001 >= rate_ticks(c.dev.conversion_rate_select)) begin
              next_c.ticks = 11'h000;
              next_c.start = 1'b1;
            end
          end else begin
            next_c.cyc = c.cyc + 32'h1;
          end
        end
        // Host writes land last, so a fresh go set here is never lost
        if (c.wr_sync[1] != c.wr_seen) begin
          if (h.wr_addr == smc_pkg::ADDR_DEV) begin
            next_c.dev = h.wr_data;
            if (next_c.dev.self_clearing_restart) begin
              next_c.st = smc_pkg::ST_SRST;
              next_c.sr_cnt = 8'(smc_pkg::SRST_CYC - 1);
            end
          end else if (h.wr_addr == smc_pkg::ADDR_MEAS) begin
            next_c.meas = h.wr_data;
          end
        end
      end
      default: next_c.st = smc_pkg::ST_IDLE;
    endcase
    // Set wins over the clear-on-read
    if (conv_done_i) begin
      next_c.flag = 1'b1;
    end else if (flag_read_i) begin
      next_c.flag = 1'b0;
    end
    alert_act = c.dev.alert_comparator ? cmp_level_i : c.flag;
    next_c.alert = c.dev.alert_polarity ? alert_act : ~alert_act;
    next_c.alert_oe_n = ~c.dev.alert_pin_drive;
    // Republish setup bytes only once the link has taken the last copy
    if (c.ack_sync[1] == c.pub_tgl && c.pub != {c.dev, c.meas}) begin
      next_c.pub = {c.dev, c.meas};
      next_c.pub_tgl = ~c.pub_tgl;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c <= '0;
      c.st <= smc_pkg::ST_IDLE;
      c.alert <= 1'b1;
      c.alert_oe_n <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  assign heater_on_o = c.dev.heater_on;
  assign temp_res_o = c.meas.temp_resolution_sel;
  assign humid_res_o = c.meas.humid_resolution_sel;
  assign chan_sel_o = c.meas.channel_select;
  assign conv_start_o = c.start;
  assign restarting_o = c.dev.self_clearing_restart;
  assign alert_o = c.alert;
  assign alert_oe_n_o = c.alert_oe_n;

  // Link domain; alert_i is the wire level, only the checks read it back
  // Frame drop clears the shifter even when the host clock has stopped
  assign frame_rst_n = rst_n_i & link_frame_i;

  always_comb begin
    next_f = f;
    next_h = h;
    next_h.pub_sync = {h.pub_sync[0], c.pub_tgl};
    if (h.pub_sync[1] != h.ack_tgl) begin
      next_h.snap = c.pub;
      next_h.ack_tgl = ~h.ack_tgl;
    end
    next_f.cnt = f.cnt + 5'h01;
    next_f.rx = {f.rx[6:0], link_sdi_i};
    next_f.tx = {f.tx[6:0], 1'b0};
    next_f.sdo = f.tx[7];
    if (f.cnt == smc_pkg::BIT_CMD_LAST) begin
      next_f.rd = link_sdi_i;
    end
    if (f.cnt == smc_pkg::BIT_ADDR_LAST) begin
      next_h.wr_addr = {f.rx[6:0], link_sdi_i};
      next_f.tx = read_byte({f.rx[6:0], link_sdi_i}, h.snap);
      next_f.oe_n = ~f.rd;
    end
    if (f.cnt == smc_pkg::BIT_FRAME_LAST && !f.rd) begin
      next_h.wr_data = {f.rx[6:0], link_sdi_i};
      next_h.wr_tgl = ~h.wr_tgl;
    end
    // Drive one edge past the frame, the host takes the last bit on that edge
    if (f.cnt == smc_pkg::BIT_FRAME_LAST + 5'h01) begin
      next_f.cnt = f.cnt;
      next_f.oe_n = 1'b1;
      next_f.sdo = 1'b0;
    end
  end

  always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f <= '0;
      f.oe_n <= 1'b1;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  assign link_sdo_o = f.sdo;
  assign link_sdo_oe_n_o = f.oe_n;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_srst_done;
    $rose(c.st == smc_pkg::ST_SRST) |-> ##[1:SR_MAX] (c.dev == 8'h00 && c.meas == 8'h00);
  endproperty
  a_srst_done: assert property (p_srst_done) else $error("Soft reset did not clear");

  property p_one_shot_quiet;
    (c.dev.conversion_rate_select == smc_pkg::RATE_ONE_SHOT && !c.meas.conversion_go)
      |=> !conv_start_o;
  endproperty
  a_one_shot_quiet: assert property (p_one_shot_quiet) else $error("Start without go");

  property p_periodic;
    (c.st == smc_pkg::ST_RUN && !c.meas.conversion_go && c.cyc == 32'(TICK_CYC - 1)
      && c.dev.conversion_rate_select != smc_pkg::RATE_ONE_SHOT
      && c.ticks + 11'h001 >= rate_ticks(c.dev.conversion_rate_select)) |=> conv_start_o;
  endproperty
  a_periodic: assert property (p_periodic) else $error("Missed periodic start");

  property p_heater;
    (c.st != smc_pkg::ST_SRST && c.wr_sync[1] != c.wr_seen && h.wr_addr == smc_pkg::ADDR_DEV)
      |=> c.dev == $past(h.wr_data) && heater_on_o == c.dev.heater_on;
  endproperty
  a_heater: assert property (p_heater) else $error("Heater output wrong");

  property p_pin_drive;
    c.dev.alert_pin_drive |=> !alert_oe_n_o;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("Alert pin not driven");

  property p_pin_readback;
    !alert_oe_n_o |-> alert_i == alert_o;
  endproperty
  a_pin_readback: assert property (p_pin_readback) else $error("Alert pin level wrong");

  property p_comparator;
    (c.dev.alert_comparator && cmp_level_i) |=> alert_o == $past(c.dev.alert_polarity);
  endproperty
  a_comparator: assert property (p_comparator) else $error("Alert level wrong");

  property p_clear_on_read;
    (!c.dev.alert_comparator && !c.dev.alert_polarity && conv_done_i) ##1
      (!c.dev.alert_comparator && !c.dev.alert_polarity) |=> !alert_o;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("Latched alert lost");

  property p_go_clears;
    (c.meas.conversion_go && c.st != smc_pkg::ST_SRST && c.wr_sync[1] == c.wr_seen)
      |=> conv_start_o && !c.meas.conversion_go;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("Go did not start");

  property p_ids;
    @(posedge link_clk_i) disable iff (!frame_rst_n)
      (f.cnt == smc_pkg::BIT_ADDR_LAST && {f.rx[6:0], link_sdi_i} == smc_pkg::ADDR_PART_HI)
      |=> f.tx == smc_pkg::PART_CODE[15:8];
  endproperty
  a_ids: assert property (p_ids) else $error("Part code byte wrong");

  c_srst: cover property ($rose(c.st == smc_pkg::ST_SRST));
  c_one_shot: cover property (conv_start_o && c.st == smc_pkg::ST_IDLE);
  c_run: cover property (conv_start_o && c.st == smc_pkg::ST_RUN);
  c_read: cover property (@(posedge link_clk_i) !f.oe_n);

endmodule // smc_top

/* include/smc_pkg.sv */
// Constants, register layouts and states for the sensor configuration block.
// Assumes a 20 MHz core clock and a framed serial link clocked by the host.
package smc_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_DEV = 8'h0e;
  localparam logic [7:0] ADDR_MEAS = 8'h0f;
  localparam logic [7:0] ADDR_MAKER_LO = 8'hfc;
  localparam logic [7:0] ADDR_MAKER_HI = 8'hfd;
  localparam logic [7:0] ADDR_PART_LO = 8'hfe;
  localparam logic [7:0] ADDR_PART_HI = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Identity codes: values are arbitrary
  localparam logic [15:0] MAKER_CODE = 16'h1a2b;
  localparam logic [15:0] PART_CODE = 16'h3c4d;

  // Device setup layout, msb first
  typedef struct packed {
    logic self_clearing_restart;
    logic [2:0] conversion_rate_select;
    logic heater_on;
    logic alert_pin_drive;
    logic alert_polarity;
    logic alert_comparator;
  } smc_dev_t;

  // Measurement setup layout, msb first
  typedef struct packed {
    logic [1:0] temp_resolution_sel;
    logic [1:0] humid_resolution_sel;
    logic spare_bit_three;
    logic [1:0] channel_select;
    logic conversion_go;
  } smc_meas_t;

  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;

  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned SRST_NS = 500;
  localparam int unsigned SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;
  // Sample periods in 100 ms ticks, per rate code 1..7
  localparam logic [10:0] TICKS_R1 = 11'h4b0;
  localparam logic [10:0] TICKS_R2 = 11'h258;
  localparam logic [10:0] TICKS_R3 = 11'h064;
  localparam logic [10:0] TICKS_R4 = 11'h032;
  localparam logic [10:0] TICKS_R5 = 11'h00a;
  localparam logic [10:0] TICKS_R6 = 11'h005;
  localparam logic [10:0] TICKS_R7 = 11'h002;

  // Link frame: command byte, address byte, data byte
  localparam logic [4:0] BIT_ADDR_LAST = 5'h0f;
  localparam logic [4:0] BIT_FRAME_LAST = 5'h17;
  localparam logic [4:0] BIT_CMD_LAST = 5'h07;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_SRST = 3'b100
  } smc_state_t;

endpackage

/* bench/smc_host.sv */
// Host model for the framed register link of the sensor block.
// Assumes the bench calls one task at a time; link clock runs in frames, and outside them only in idle_edges around reset.
`timescale 1ns/1ps
module smc_host (
  // Link toward the device
  output logic link_clk_o,
  output logic link_frame_o,
  output logic link_sdi_o,
  input wire logic link_sdo_i,
  // Read results
  output logic [7:0] rd_data_o,
  output logic rd_done_o
);
  initial begin
    link_clk_o = 1'b0;
    link_frame_o = 1'b0;
    link_sdi_o = 1'b0;
    rd_data_o = 8'h00;
    rd_done_o = 1'b0;
  end

  // Bare edges with the frame low, only around reset
  task automatic idle_edges(input int n);
    repeat (n) begin
      #15 link_clk_o = 1'b1;
      #15 link_clk_o = 1'b0;
    end
  endtask

  // One frame; a read runs one extra edge to catch the last data bit
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                      input logic note);
    logic [23:0] f;
    f = {7'h00, rd, a, wd};
    #(15 + $urandom % 30);
    link_frame_o = 1'b1;
    for (int i = 0; i < (rd ? 25 : 24); i++) begin
      link_sdi_o = (i < 24) ? f[23 - i] : ~link_sdi_o;
      #15;
      if (i >= 17) rd_data_o = {rd_data_o[6:0], link_sdo_i};
      link_clk_o = 1'b1;
      #15 link_clk_o = 1'b0;
    end
    #15 link_frame_o = 1'b0;
    link_sdi_o = ~link_sdi_o;
    if (rd && note) begin
      rd_done_o = 1'b1;
      #1 rd_done_o = 1'b0;
    end
  endtask
endmodule // smc_host

/* bench/tb_smc_top.sv */
// Self-checking bench for the sensor configuration block.
// Assumes smc_host drives the link; the bench plays the measurement engine.
`timescale 1ns/1ps
module tb_smc_top;
  localparam int unsigned TICK = 10;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic conv_done = 1'b0;
  logic cmp_level = 1'b0;
  logic flag_read = 1'b0;
  logic lclk, lfrm, lsdi, lsdo, lsdo_oe_n, conv_start, heater, restarting;
  logic alert, alert_oe_n, alert_pin, rd_done;
  logic [1:0] temp_res, humid_res, chan_sel;
  logic [7:0] rd_data;
  logic [7:0] v;
  logic [31:0] ids;
  logic [7:0] exp_q[$];
  int tk[8] = '{0, 1200, 600, 100, 50, 10, 5, 2};
  int failures = 0;
  int tests_run = 0;
  int n_start = 0;
  int cyc = 0;
  int last_at = 0;
  int t0, t1;
  // Pulled up while the device leaves the pin floating
  assign alert_pin = alert_oe_n ? 1'b1 : alert;

  always #25 core_clk_i = ~core_clk_i;

  smc_host u_host (
    // Released data line reads as pulled up
    .link_clk_o(lclk), .link_frame_o(lfrm), .link_sdi_o(lsdi),
    .link_sdo_i(lsdo_oe_n ? 1'b1 : lsdo),
    .rd_data_o(rd_data), .rd_done_o(rd_done)
  );
  smc_top #(.TICK_CYC(TICK)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(lclk), .link_frame_i(lfrm),
    .link_sdi_i(lsdi), .link_sdo_o(lsdo), .link_sdo_oe_n_o(lsdo_oe_n),
    .conv_done_i(conv_done), .cmp_level_i(cmp_level), .flag_read_i(flag_read),
    .conv_start_o(conv_start), .temp_res_o(temp_res), .humid_res_o(humid_res),
    .chan_sel_o(chan_sel), .heater_on_o(heater), .restarting_o(restarting),
    .alert_i(alert_pin), .alert_o(alert), .alert_oe_n_o(alert_oe_n)
  );

  task automatic report_and_stop();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, 1'b0);
    cyc_wait(10);
  endtask

  // First frame only refreshes the crossed snapshot
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b1, a, 8'h5a, 1'b0);
    u_host.xfer(1'b1, a, 8'h5a, 1'b1);
    cyc_wait(2);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc_wait(1);
    s = 1'b0;
    cyc_wait(4);
  endtask

  task automatic next_start(output int at);
    int n;
    n = n_start;
    wait (n_start != n);
    #1;
    at = last_at;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) begin
      n_start <= n_start + 1;
      last_at <= cyc;
    end
    if (cyc == 100000) begin
      failures++;
      report_and_stop();
    end
  end

  // Read results arrive in order of request
  always @(posedge rd_done) begin
    if (exp_q.size() == 0) failures++;
    else check(rd_data, exp_q.pop_front(), "read");
  end

  initial begin
    void'($urandom(32'hd55635e2));
    fork
      u_host.idle_edges(3);
      cyc_wait(3);
    join
    rst_n_i = 1'b1;
    u_host.idle_edges(3);
    wr(smc_pkg::ADDR_MAKER_LO, 8'hff);
    rd(smc_pkg::ADDR_DEV, 8'h00);
    rd(smc_pkg::ADDR_MEAS, 8'h00);
    rd(8'h10, 8'h00);
    ids = {smc_pkg::PART_CODE, smc_pkg::MAKER_CODE};
    for (int i = 0; i < 4; i++) rd(8'hfc + 8'(i), ids[8*i +: 8]);
    for (int i = 0; i < 8; i++) begin
      v = {4'h0, 1'($urandom), i[2:0]};
      wr(smc_pkg::ADDR_DEV, v);
      check(heater, v[3], "heater");
      check(alert_oe_n, !v[2], "pin drive");
      rd(smc_pkg::ADDR_DEV, v);
      if (v[2]) begin
        check(alert, !v[1], "idle level");
        if (v[0]) cmp_level = 1'b1;
        else pulse(conv_done);
        cyc_wait(4);
        check(alert, v[1], "active level");
        cmp_level = 1'b0;
        pulse(flag_read);
        cyc_wait(4);
        check(alert, !v[1], "cleared");
      end
    end
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], ~i[1:0], 1'($urandom), i[1:0], 1'b0};
      wr(smc_pkg::ADDR_MEAS, v);
      check({temp_res, humid_res, chan_sel}, {v[7:4], v[2:1]}, "fields");
      rd(smc_pkg::ADDR_MEAS, v);
    end
    check(n_start, 0, "go zero");
    t0 = n_start;
    wr(smc_pkg::ADDR_MEAS, 8'h01);
    cyc_wait(100);
    check(n_start - t0, 1, "one shot");
    rd(smc_pkg::ADDR_MEAS, 8'h00);
    for (int r = 1; r < 8; r++) begin
      wr(smc_pkg::ADDR_DEV, {1'b0, r[2:0], 4'h0});
      wr(smc_pkg::ADDR_MEAS, 8'h01);
      next_start(t0);
      next_start(t1);
      check(t1 - t0, tk[r] * TICK, "period");
      wr(smc_pkg::ADDR_DEV, 8'h00);
    end
    t0 = n_start;
    cyc_wait(200);
    check(n_start - t0, 0, "stopped");
    wr(smc_pkg::ADDR_MEAS, 8'hf6);
    u_host.xfer(1'b0, smc_pkg::ADDR_DEV, 8'h8c, 1'b0);
    cyc_wait(6);
    check(restarting, 1'b1, "restart held");
    cyc_wait(20);
    check({restarting, heater}, 2'b00, "restart done");
    check({temp_res, humid_res, chan_sel}, 6'h00, "meas cleared");
    rd(smc_pkg::ADDR_DEV, 8'h00);
    rd(smc_pkg::ADDR_MEAS, 8'h00);
    report_and_stop();
  end
endmodule // tb_smc_top
